// ==== rtl/fsc_pkg.sv ====
// Shared constants and types for the flash status and configuration register logic
package fsc_pkg;

  // Command opcodes
  localparam logic [7:0] OP_WR_ST = 8'h01;
  localparam logic [7:0] OP_WR_ST_HI = 8'h31;
  localparam logic [7:0] OP_WR_CFG = 8'h11;
  localparam logic [7:0] OP_RD_ST_LO = 8'h05;
  localparam logic [7:0] OP_RD_ST_HI = 8'h35;
  localparam logic [7:0] OP_RD_CFG = 8'h15;
  localparam logic [7:0] OP_WR_EN = 8'h06;
  localparam logic [7:0] OP_WR_DIS = 8'h04;
  localparam logic [7:0] OP_VOL_WR_EN = 8'h50;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7A;

  // Status word bit positions
  localparam int SB_BUSY = 0;
  localparam int SB_WE_LATCH = 1;
  localparam int SB_BP_LO = 2;
  localparam int SB_BP_HI = 6;
  localparam int SB_RP0 = 7;
  localparam int SB_RP1 = 8;
  localparam int SB_QUAD = 9;
  localparam int SB_FAIL = 10;
  localparam int SB_LOCK_LO = 11;
  localparam int SB_LOCK_HI = 13;
  localparam int SB_COMP = 14;
  localparam int SB_SUSPEND = 15;

  // Config byte bit positions
  localparam int CB_LEARN = 0;
  localparam int CB_DUMMY = 1;
  localparam int CB_SCHEME = 2;
  localparam int CB_RSV_LO = 3;
  localparam int CB_RSV_HI = 4;
  localparam int CB_DRV_LO = 5;
  localparam int CB_DRV_HI = 6;
  localparam int CB_PIN_RST = 7;

  // Reset values and write masks
  localparam logic [15:0] STATUS_RST = 16'h0000;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [15:0] ST_KEEP_MASK = 16'h8403;
  localparam logic [15:0] ST_LOCK_MASK = 16'h3800;
  localparam logic [7:0] CFG_WR_MASK = 8'hE7;
  localparam logic [7:0] CFG_NV_MASK = 8'hE4;

  // Bit counts on the link
  localparam logic [4:0] CMD_LAST = 5'h07;
  localparam logic [4:0] BYTE_BITS = 5'h08;
  localparam logic [4:0] WORD_BITS = 5'h10;
  localparam logic [4:0] CNT_SAT = 5'h1F;

  // Drive strength in percent, indexed by the two drive bits
  localparam logic [7:0] DRV_PCT_00 = 8'h64;
  localparam logic [7:0] DRV_PCT_01 = 8'h32;
  localparam logic [7:0] DRV_PCT_10 = 8'h7D;
  localparam logic [7:0] DRV_PCT_11 = 8'h96;

  // Dummy clocks per read kind for dummy select 0 and 1
  localparam logic [3:0] DUMMY_DUAL_0 = 4'h4;
  localparam logic [3:0] DUMMY_DUAL_1 = 4'h8;
  localparam logic [3:0] DUMMY_QUAD_0 = 4'h6;
  localparam logic [3:0] DUMMY_QUAD_1 = 4'hA;
  localparam logic [3:0] DUMMY_DTR_0 = 4'h8;
  localparam logic [3:0] DUMMY_DTR_1 = 4'hA;

  localparam logic [7:0] LEARN_PATTERN = 8'h34;

  // Self-timed status write; the time is a plain default, not a device figure
  localparam int STATUS_WRITE_TIME_US = 5;
  localparam int CLK_MHZ = 200;
  localparam int WRITE_CYCLES_DEF = STATUS_WRITE_TIME_US * CLK_MHZ;

  // Pin order into the synchroniser and the idle level of each pin
  localparam int LK_PINS = 5;
  localparam int LK_SCLK = 0;
  localparam int LK_CS = 1;
  localparam int LK_SI = 2;
  localparam int LK_WP = 3;
  localparam int LK_MF = 4;
  localparam logic [4:0] LINK_IDLE = 5'h1A;

  typedef enum logic [1:0] {S_CMD, S_READ, S_DATA, S_SKIP} fsc_state_t;

  typedef struct packed {
    logic sclk_rise;
    logic sclk_fall;
    logic cs_n;
    logic cs_rise;
    logic si;
    logic wp_n;
    logic mf_n;
  } fsc_link_t;

  typedef struct packed {
    logic scheme;
    logic comp;
    logic [4:0] bp;
  } fsc_prot_t;

endpackage : fsc_pkg

// ==== rtl/fsc_link_sync.sv ====
// Two-flop synchronisers and edge detection for the serial link pins
`timescale 1ns/1ps
module fsc_link_sync import fsc_pkg::*; (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [LK_PINS-1:0] pins,
  output fsc_link_t link
);

  logic [LK_PINS-1:0] meta_q;
  logic [LK_PINS-1:0] sync_q;
  logic [1:0] prev_q;

  for (genvar i = 0; i < LK_PINS; i++) begin : g_sync
    always_ff @(posedge ref_clk) begin
      if (!rstn) begin
        meta_q[i] <= LINK_IDLE[i];
        sync_q[i] <= LINK_IDLE[i];
      end else begin
        meta_q[i] <= pins[i];
        sync_q[i] <= meta_q[i];
      end
    end
  end

  // Edges are found on the second stage only, never on the metastable one
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      prev_q <= LINK_IDLE[LK_CS:LK_SCLK];
    end else begin
      prev_q <= sync_q[LK_CS:LK_SCLK];
    end
  end

  assign link.sclk_rise = sync_q[LK_SCLK] & ~prev_q[LK_SCLK];
  assign link.sclk_fall = ~sync_q[LK_SCLK] & prev_q[LK_SCLK];
  assign link.cs_n = sync_q[LK_CS];
  assign link.cs_rise = sync_q[LK_CS] & ~prev_q[LK_CS];
  assign link.si = sync_q[LK_SI];
  assign link.wp_n = sync_q[LK_WP];
  assign link.mf_n = sync_q[LK_MF];

endmodule : fsc_link_sync

// ==== rtl/fsc_regs.sv ====
// Status word and config byte of a serial flash, reached over its command link
// Behaviour
// - Failure flag sets on failed, reset-interrupted or protected program/erase.
// - Failure flag clears on next successful operation; never stops an operation.
// - Three security lock bits, once 1, stay 1 and make security regions read-only.
// - Lock bits reset to 0 and are set individually by a status write.
// - Complement bit joins the five block-protect bits to pick the protected area.
// - Suspend flag set by 75H, cleared by 7AH or any reset.
// - Config read 15H is accepted at any time, even while busy.
// - Config read shifts the byte out on the serial output; upper lines ignored.
// - Config bit 7 picks hold or reset pin function, only while quad is off.
// - Drive bits select 100, 50, 125 or 150 percent output drive.
// - Scheme bit picks area protection at 0, individual block locks at 1.
// - All individual block locks are 1 after power-on and any reset.
// - Dummy bit selects 4/8 dual, 6/10 quad, 8/10 DTR quad dummy clocks.
// - Learn enable drives 00110100 on every line in DTR dummy cycles.
// - A status write without the write-enable latch set is rejected.
// - Status writes never change suspend, failure, write-enable latch or busy.
// - Status write only runs if chip select rises after data bit 8 or 16.
// - With only eight data bits the upper status byte keeps its value.
// - Valid write starts a timed cycle, busy held, then busy and latch clear.
// - Status reads keep working during the timed write cycle.
// - Status writes are ignored in hardware protected mode.
// - Upper byte comes as second byte after 01H or sole byte after 31H.
// - 05H returns the low status byte, 35H the high status byte.
// - Protect bits 0,1 with write-protect pin low lock both registers; the code ignores the pin while quad is on.
// - Write after 50H changes volatile copies only, no write-enable latch.
`timescale 1ns/1ps
module fsc_regs import fsc_pkg::*; #(
  parameter int WRITE_CYCLES = WRITE_CYCLES_DEF
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic serial_io0,
  input wire logic wp_n,
  input wire logic mf_n,
  input wire logic op_busy,
  input wire logic op_done,
  input wire logic op_ok,
  input wire logic op_prot_hit,
  input wire logic dtr_dummy,
  input wire logic [2:0] dummy_idx,
  output logic serial_io1_q,
  output logic serial_io1_oe_q,
  output logic [15:0] status_word_q,
  output logic [7:0] config_byte_q,
  output logic busy_bit_q,
  output logic hold_active_q,
  output logic lock_preset_q,
  output logic [2:0] sec_lock_q,
  output fsc_prot_t prot_cfg_q,
  output logic [7:0] drive_pct_q,
  output logic [3:0] dummy_dual_q,
  output logic [3:0] dummy_quad_q,
  output logic [3:0] dummy_dtr_q,
  output logic [3:0] learn_io_q,
  output logic learn_oe_q
);

  fsc_link_t lk;
  fsc_state_t state_q;
  logic [4:0] bit_cnt_q;
  logic [7:0] op_q;
  logic [15:0] sh_q;
  logic [2:0] rd_idx_q;
  logic [15:2] stat_q;
  logic [7:0] cfg_q;
  logic we_latch_q;
  logic vol_arm_q;
  logic wcyc_q;
  logic [19:0] cyc_q;
  logic [15:2] pend_st_q;
  logic [7:0] pend_cfg_q;

  fsc_link_sync u_sync (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .pins({mf_n, wp_n, serial_io0, cs_n, sclk}),
    .link(lk)
  );

  // Command framing
  wire [7:0] op_w = {sh_q[6:0], lk.si};
  wire cmd_byte_done = !lk.cs_n && lk.sclk_rise && state_q == S_CMD && bit_cnt_q == CMD_LAST;
  wire op_is_read = op_w == OP_RD_ST_LO || op_w == OP_RD_ST_HI || op_w == OP_RD_CFG;
  wire op_is_write = op_w == OP_WR_ST || op_w == OP_WR_ST_HI || op_w == OP_WR_CFG;
  wire cmd_end = lk.cs_rise && state_q != S_CMD;
  wire simple_end = cmd_end && state_q == S_SKIP && bit_cnt_q == 5'h00;
  wire busy_w = wcyc_q | op_busy;
  wire [15:0] status_w = {stat_q, we_latch_q, busy_w};

  // Reset pin function only exists with quad off
  wire hard_rst_w = !stat_q[SB_QUAD] && cfg_q[CB_PIN_RST] && !lk.mf_n;
  wire hw_locked_w = stat_q[SB_RP1]
                     || (stat_q[SB_RP0] && !lk.wp_n && !stat_q[SB_QUAD]);

  wire len_ok = (op_q == OP_WR_ST && (bit_cnt_q == BYTE_BITS || bit_cnt_q == WORD_BITS))
                || ((op_q == OP_WR_ST_HI || op_q == OP_WR_CFG) && bit_cnt_q == BYTE_BITS);
  wire wr_allowed = (we_latch_q || vol_arm_q) && !busy_w && !hw_locked_w;
  wire wr_go = cmd_end && state_q == S_DATA && len_ok && wr_allowed && !hard_rst_w;
  wire wr_cfg = op_q == OP_WR_CFG;
  wire vol_go = wr_go && vol_arm_q;
  wire nv_go = wr_go && !vol_arm_q;

  // Assemble the word: 01H sends low byte first, 31H carries the high byte alone
  wire [15:0] wr_word_w = (op_q == OP_WR_ST_HI) ? {sh_q[7:0], status_w[7:0]} :
                          (bit_cnt_q == WORD_BITS) ? {sh_q[7:0], sh_q[15:8]} :
                          {status_w[15:8], sh_q[7:0]};
  wire [15:0] lock_new_w = wr_word_w & ST_LOCK_MASK & {16{~vol_arm_q}};
  wire [15:0] st_merge_w = (status_w & ST_KEEP_MASK)
                           | (wr_word_w & ~ST_KEEP_MASK & ~ST_LOCK_MASK)
                           | (status_w & ST_LOCK_MASK) | lock_new_w;
  wire [7:0] cfg_merge_w = sh_q[7:0] & CFG_WR_MASK;

  wire commit_w = wcyc_q && cyc_q == 20'h0_0000 && !hard_rst_w;
  wire commit_st = commit_w && !pend_cfg_q[CB_RSV_LO];
  wire commit_cfg = commit_w && pend_cfg_q[CB_RSV_LO];

  // Hardware-set flags: the set wins over any clear in the same cycle
  wire fail_set = (op_done && !op_ok) || op_prot_hit || (hard_rst_w && op_busy);
  wire fail_clr = op_done && op_ok;
  wire fail_d = fail_set || (stat_q[SB_FAIL] && !fail_clr);
  wire sus_set = simple_end && op_q == OP_SUSPEND;
  wire sus_clr = (simple_end && op_q == OP_RESUME) || hard_rst_w;
  wire sus_d = sus_set || (stat_q[SB_SUSPEND] && !sus_clr);

  wire [15:2] st_base_w = commit_st ? pend_st_q :
                          (vol_go && !wr_cfg) ? st_merge_w[15:2] : stat_q;
  wire [15:2] stat_d = {sus_d, st_base_w[14:11], fail_d, st_base_w[9:2]};
  wire [7:0] cfg_d = hard_rst_w ? (cfg_q & CFG_NV_MASK) :
                     commit_cfg ? (pend_cfg_q & CFG_WR_MASK) :
                     (vol_go && wr_cfg) ? cfg_merge_w : cfg_q;

  wire we_set = simple_end && op_q == OP_WR_EN;
  wire we_clr = commit_w || hard_rst_w || (simple_end && (op_q == OP_WR_DIS || op_q == OP_VOL_WR_EN));
  wire we_latch_d = !we_clr && (we_set || we_latch_q);

  // Live read so that polling during the write cycle sees busy change
  wire [7:0] rd_byte_w = (op_q == OP_RD_ST_LO) ? status_w[7:0] :
                         (op_q == OP_RD_ST_HI) ? status_w[15:8] : cfg_q;

  wire [7:0] drive_w = cfg_q[CB_DRV_HI] ? (cfg_q[CB_DRV_LO] ? DRV_PCT_11 : DRV_PCT_10) :
                       (cfg_q[CB_DRV_LO] ? DRV_PCT_01 : DRV_PCT_00);
  wire dsel = cfg_q[CB_DUMMY];
  wire learn_on = dtr_dummy && cfg_q[CB_LEARN];

  // Link framing state
  always_ff @(posedge ref_clk) begin
    if (!rstn || lk.cs_n) begin
      state_q <= S_CMD;
      bit_cnt_q <= 5'h00;
    end else if (cmd_byte_done) begin
      state_q <= op_is_read ? S_READ : (op_is_write ? S_DATA : S_SKIP);
      bit_cnt_q <= 5'h00;
    end else if (lk.sclk_rise && bit_cnt_q != CNT_SAT) begin
      bit_cnt_q <= bit_cnt_q + 5'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      sh_q <= 16'h0000;
      op_q <= 8'h00;
    end else begin
      if (!lk.cs_n && lk.sclk_rise) sh_q <= {sh_q[14:0], lk.si};
      if (cmd_byte_done) op_q <= op_w;
    end
  end

  // Data leaves on falling edges, MSB first; upper IO lines are never read
  always_ff @(posedge ref_clk) begin
    if (!rstn || state_q != S_READ) begin
      rd_idx_q <= 3'h0;
      serial_io1_q <= 1'b0;
    end else if (lk.sclk_fall) begin
      serial_io1_q <= rd_byte_w[~rd_idx_q];
      rd_idx_q <= rd_idx_q + 3'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      stat_q <= STATUS_RST[15:2];
      cfg_q <= CFG_RST;
      we_latch_q <= 1'b0;
      vol_arm_q <= 1'b0;
    end else begin
      stat_q <= stat_d;
      cfg_q <= cfg_d;
      we_latch_q <= we_latch_d;
      if (cmd_end || hard_rst_w) vol_arm_q <= simple_end && op_q == OP_VOL_WR_EN;
    end
  end

  // Self-timed write cycle; a hard reset aborts it without commit
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      wcyc_q <= 1'b0;
      cyc_q <= 20'h0_0000;
      pend_st_q <= STATUS_RST[15:2];
      pend_cfg_q <= CFG_RST;
    end else if (nv_go) begin
      wcyc_q <= 1'b1;
      cyc_q <= 20'(WRITE_CYCLES - 1);
      pend_st_q <= st_merge_w[15:2];
      pend_cfg_q <= wr_cfg ? (cfg_merge_w | 8'h08) : 8'h00;
    end else if (wcyc_q) begin
      wcyc_q <= !(commit_w || hard_rst_w);
      cyc_q <= cyc_q - 20'h0_0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      serial_io1_oe_q <= 1'b0;
      status_word_q <= STATUS_RST;
      config_byte_q <= CFG_RST;
      busy_bit_q <= 1'b0;
      hold_active_q <= 1'b0;
      lock_preset_q <= 1'b1;
      sec_lock_q <= 3'h0;
      prot_cfg_q <= '0;
      drive_pct_q <= DRV_PCT_00;
      dummy_dual_q <= DUMMY_DUAL_0;
      dummy_quad_q <= DUMMY_QUAD_0;
      dummy_dtr_q <= DUMMY_DTR_0;
      learn_io_q <= 4'h0;
      learn_oe_q <= 1'b0;
    end else begin
      serial_io1_oe_q <= state_q == S_READ && !lk.cs_n;
      status_word_q <= status_w;
      config_byte_q <= cfg_q;
      busy_bit_q <= busy_w;
      hold_active_q <= !stat_q[SB_QUAD] && !cfg_q[CB_PIN_RST] && !lk.mf_n;
      lock_preset_q <= hard_rst_w;
      sec_lock_q <= stat_q[SB_LOCK_HI:SB_LOCK_LO];
      prot_cfg_q <= '{scheme: cfg_q[CB_SCHEME], comp: stat_q[SB_COMP],
                      bp: stat_q[SB_BP_HI:SB_BP_LO]};
      drive_pct_q <= drive_w;
      dummy_dual_q <= dsel ? DUMMY_DUAL_1 : DUMMY_DUAL_0;
      dummy_quad_q <= dsel ? DUMMY_QUAD_1 : DUMMY_QUAD_0;
      dummy_dtr_q <= dsel ? DUMMY_DTR_1 : DUMMY_DTR_0;
      learn_io_q <= {4{learn_on & LEARN_PATTERN[~dummy_idx]}};
      learn_oe_q <= learn_on;
    end
  end

  // Helper for the cycle-length check
  logic [19:0] hold_len_q;
  always_ff @(posedge ref_clk) begin
    if (!rstn || !wcyc_q) hold_len_q <= 20'h0_0000;
    else hold_len_q <= hold_len_q + 20'h0_0001;
  end

  property p_fail_set;
    @(posedge ref_clk) disable iff (!rstn) ((op_done && !op_ok) || op_prot_hit) |=> stat_q[SB_FAIL];
  endproperty
  a_fail_set: assert property (p_fail_set) else $error("failure flag not set");

  property p_fail_clr;
    @(posedge ref_clk) disable iff (!rstn)
      (op_done && op_ok && !op_prot_hit && !hard_rst_w) |=> !stat_q[SB_FAIL] ##1 busy_bit_q == $past(busy_w);
  endproperty
  a_fail_clr: assert property (p_fail_clr) else $error("failure flag not cleared");

  property p_lock_otp;
    @(posedge ref_clk) disable iff (!rstn)
      ##1 ((stat_q[SB_LOCK_HI:SB_LOCK_LO] & $past(stat_q[SB_LOCK_HI:SB_LOCK_LO]))
           == $past(stat_q[SB_LOCK_HI:SB_LOCK_LO]));
  endproperty
  a_lock_otp: assert property (p_lock_otp) else $error("security lock bit cleared");

  property p_hw_reject;
    @(posedge ref_clk) disable iff (!rstn)
      (cmd_end && state_q == S_DATA && hw_locked_w && !wcyc_q) |=> !wcyc_q [*2];
  endproperty
  a_hw_reject: assert property (p_hw_reject) else $error("write ran while protected");

  property p_we_needed;
    @(posedge ref_clk) disable iff (!rstn)
      (cmd_end && state_q == S_DATA && !we_latch_q && !vol_arm_q) |=> !wcyc_q && $stable(stat_q[SB_BP_HI:SB_BP_LO]);
  endproperty
  a_we_needed: assert property (p_we_needed) else $error("write ran without latch");

  property p_cycle_len;
    @(posedge ref_clk) disable iff (!rstn)
      ($fell(wcyc_q) && !$past(hard_rst_w)) |-> hold_len_q == WRITE_CYCLES && !we_latch_q;
  endproperty
  a_cycle_len: assert property (p_cycle_len) else $error("write cycle length wrong");

  property p_keep_fields;
    @(posedge ref_clk) disable iff (!rstn)
      (commit_st && !fail_set && !fail_clr && !cmd_end) |=> $stable(stat_q[SB_FAIL]) && $stable(stat_q[SB_SUSPEND]);
  endproperty
  a_keep_fields: assert property (p_keep_fields) else $error("write touched flags");

  property p_hi_keep;
    @(posedge ref_clk) disable iff (!rstn)
      (nv_go && op_q == OP_WR_ST && bit_cnt_q == BYTE_BITS) |=> pend_st_q[15:8] == $past(stat_q[15:8]);
  endproperty
  a_hi_keep: assert property (p_hi_keep) else $error("upper byte changed by short write");

  property p_suspend;
    @(posedge ref_clk) disable iff (!rstn)
      (simple_end && op_q == OP_SUSPEND) |=> stat_q[SB_SUSPEND] ##1 status_word_q[SB_SUSPEND];
  endproperty
  a_suspend: assert property (p_suspend) else $error("suspend flag not set");

  property p_rsv_zero;
    @(posedge ref_clk) disable iff (!rstn) config_byte_q[CB_RSV_HI:CB_RSV_LO] == 2'b00;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved config bits set");

  property p_learn_off;
    @(posedge ref_clk) disable iff (!rstn) (dtr_dummy && !cfg_q[CB_LEARN]) |=> !learn_oe_q && learn_io_q == 4'h0;
  endproperty
  a_learn_off: assert property (p_learn_off) else $error("pattern driven while disabled");

endmodule : fsc_regs

// ==== verification/fsc_ctl_model.sv ====
// Flash controller model that drives the serial command link, mode 0, MSB first
`timescale 1ns/1ps
module fsc_ctl_model (
  input wire logic ref_clk,
  output logic sclk,
  output logic cs_n,
  output logic serial_io0,
  input wire logic serial_io1_q
);
  // Half a link period in ref_clk cycles: 160 ns link clock on a 5 ns clock
  localparam int HALF = 16;

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    serial_io0 = 1'b0;
  end

  // Link clock stands low outside frames; the data line toggles once released
  task automatic frame(input logic [7:0] op, input logic [15:0] dat, input int nd,
                       input int nr, output logic [7:0] rd);
    logic [23:0] v;
    v = (nd == 8) ? {op, dat[7:0], 8'h00} : {op, dat};
    rd = 8'h00;
    @(posedge ref_clk) cs_n <= 1'b0;
    for (int i = 0; i < 8 + nd + nr; i++) begin
      serial_io0 <= (i < 8 + nd) ? v[23-i] : ~serial_io0;
      repeat (HALF) @(posedge ref_clk);
      if (i >= 8) begin
        rd = {rd[6:0], serial_io1_q};
      end
      sclk <= 1'b1;
      repeat (HALF) @(posedge ref_clk);
      sclk <= 1'b0;
    end
    repeat (HALF) @(posedge ref_clk);
    cs_n <= 1'b1;
    serial_io0 <= ~serial_io0;
    // Gap before the next frame, well above the four cycles the block needs
    repeat (8) @(posedge ref_clk);
  endtask : frame
endmodule : fsc_ctl_model

// ==== verification/fsc_regs_tb_top.sv ====
// Self-checking bench for the status and config register block
`timescale 1ns/1ps
module fsc_regs_tb_top import fsc_pkg::*; ;
  // Long enough that a whole read frame fits inside one write cycle
  localparam int WC = 2000;
  logic ref_clk, rstn, sclk, cs_n, serial_io0, wp_n, mf_n;
  logic op_busy, op_done, op_ok, op_prot_hit, dtr_dummy;
  logic [2:0] dummy_idx, sec_lock_q;
  logic serial_io1_q, serial_io1_oe_q, busy_bit_q, hold_active_q, lock_preset_q, learn_oe_q;
  logic [15:0] status_word_q;
  logic [7:0] config_byte_q, drive_pct_q, rd;
  fsc_prot_t prot_cfg_q;
  logic [3:0] dummy_dual_q, dummy_quad_q, dummy_dtr_q, learn_io_q;
  int err_count = 0;
  int comparisons = 0;
  logic [7:0] pct [4] = '{8'h64, 8'h32, 8'h7D, 8'h96};

  fsc_regs #(.WRITE_CYCLES(WC)) DUT (.ref_clk(ref_clk), .rstn(rstn), .sclk(sclk),
    .cs_n(cs_n), .serial_io0(serial_io0), .wp_n(wp_n), .mf_n(mf_n), .op_busy(op_busy),
    .op_done(op_done), .op_ok(op_ok), .op_prot_hit(op_prot_hit), .dtr_dummy(dtr_dummy),
    .dummy_idx(dummy_idx), .serial_io1_q(serial_io1_q), .serial_io1_oe_q(serial_io1_oe_q),
    .status_word_q(status_word_q), .config_byte_q(config_byte_q), .busy_bit_q(busy_bit_q),
    .hold_active_q(hold_active_q), .lock_preset_q(lock_preset_q), .sec_lock_q(sec_lock_q),
    .prot_cfg_q(prot_cfg_q), .drive_pct_q(drive_pct_q), .dummy_dual_q(dummy_dual_q),
    .dummy_quad_q(dummy_quad_q), .dummy_dtr_q(dummy_dtr_q), .learn_io_q(learn_io_q),
    .learn_oe_q(learn_oe_q));
  fsc_ctl_model ctl (.ref_clk(ref_clk), .sclk(sclk), .cs_n(cs_n), .serial_io0(serial_io0),
    .serial_io1_q(serial_io1_q));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc
  task automatic fr(input logic [7:0] op, input logic [15:0] d, input int nd, input int nr);
    ctl.frame(op, d, nd, nr, rd);
  endtask : fr
  // Write enable then one write frame
  task automatic wr(input logic [7:0] op, input logic [15:0] d, input int nd);
    fr(OP_WR_EN, 16'h0000, 0, 0);
    fr(op, d, nd, 0);
  endtask : wr
  task automatic idle();
    int n;
    n = 0;
    while (busy_bit_q !== 1'b0 && n < 3 * WC) begin
      cyc(1);
      n++;
    end
    cyc(2);
    chk(16'(n < 3 * WC), 16'h0001);
  endtask : idle

  task automatic t_reset();
    chk(status_word_q, STATUS_RST);
    chk(16'(config_byte_q), 16'(CFG_RST));
    chk(16'(lock_preset_q), 16'h0000);
    chk(16'(drive_pct_q), 16'h0064);
    chk(16'({dummy_dual_q, dummy_quad_q, dummy_dtr_q}), 16'h0468);
    // Output enable must be up once the opcode is in and down after the frame
    fork
      fr(OP_RD_ST_LO, 16'h0000, 0, 8);
      begin
        repeat (400) @(posedge ref_clk);
        chk(16'(serial_io1_oe_q), 16'h0001);
      end
    join
    chk(16'(rd), 16'h0000);
    chk(16'(serial_io1_oe_q), 16'h0000);
    $display("test reset done");
  endtask : t_reset
  task automatic t_word();
    fr(OP_WR_ST, 16'h00FF, 8, 0);
    chk(16'(busy_bit_q), 16'h0000);
    wr(OP_WR_ST, 16'h7FC4, 16);
    chk(16'(busy_bit_q), 16'h0001);
    fr(OP_RD_ST_LO, 16'h0000, 0, 8);
    chk(16'(rd), 16'h0003);
    fr(OP_RD_CFG, 16'h0000, 0, 8);
    chk(16'(rd), 16'h0000);
    idle();
    chk(status_word_q, 16'h407C);
    chk(16'(prot_cfg_q), 16'h003F);
    $display("test word write done");
  endtask : t_word
  task automatic t_byte();
    wr(OP_WR_ST, 16'h0000, 8);
    idle();
    chk(status_word_q, 16'h4000);
    wr(OP_WR_ST, 16'h0AB0, 12);
    cyc(2);
    chk(16'(busy_bit_q), 16'h0000);
    wr(OP_WR_ST_HI, 16'h0008, 8);
    idle();
    chk(16'(sec_lock_q), 16'h0001);
    wr(OP_WR_ST_HI, 16'h0000, 8);
    idle();
    chk(16'(sec_lock_q), 16'h0001);
    fr(OP_RD_ST_HI, 16'h0000, 0, 8);
    chk(16'(rd), 16'h0008);
    $display("test byte write done");
  endtask : t_byte
  task automatic t_cfg();
    for (int k = 0; k < 4; k++) begin
      wr(OP_WR_CFG, 16'({1'b0, k[1:0], 5'b11100}), 8);
      idle();
      chk(16'(config_byte_q), 16'({1'b0, k[1:0], 5'b00100}));
      chk(16'(drive_pct_q), 16'(pct[k]));
    end
    chk(16'(prot_cfg_q.scheme), 16'h0001);
    fr(OP_RD_CFG, 16'h0000, 0, 8);
    chk(16'(rd), 16'h0064);
    @(posedge ref_clk) mf_n <= 1'b0;
    cyc(4);
    chk(16'(hold_active_q), 16'h0001);
    @(posedge ref_clk) mf_n <= 1'b1;
    $display("test config done");
  endtask : t_cfg
  task automatic t_vol();
    fr(OP_VOL_WR_EN, 16'h0000, 0, 0);
    fr(OP_WR_CFG, 16'h0003, 8, 0);
    cyc(2);
    chk(16'({busy_bit_q, status_word_q[SB_WE_LATCH]}), 16'h0000);
    chk(16'(config_byte_q[1:0]), 16'h0003);
    chk(16'({dummy_dual_q, dummy_quad_q, dummy_dtr_q}), 16'h08AA);
    @(posedge ref_clk) dtr_dummy <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk) dummy_idx <= i[2:0];
      cyc(3);
      chk(16'({learn_oe_q, learn_io_q}), 16'({1'b1, {4{LEARN_PATTERN[7-i]}}}));
    end
    @(posedge ref_clk) dtr_dummy <= 1'b0;
    $display("test volatile done");
  endtask : t_vol
  task automatic t_flags();
    fr(OP_SUSPEND, 16'h0000, 0, 0);
    chk(16'(status_word_q[SB_SUSPEND]), 16'h0001);
    fr(OP_RESUME, 16'h0000, 0, 0);
    chk(16'(status_word_q[SB_SUSPEND]), 16'h0000);
    @(posedge ref_clk) op_done <= 1'b1;
    @(posedge ref_clk) op_done <= 1'b0;
    cyc(3);
    chk(16'(status_word_q[SB_FAIL]), 16'h0001);
    @(posedge ref_clk) {op_done, op_ok} <= 2'b11;
    @(posedge ref_clk) {op_done, op_ok} <= 2'b00;
    cyc(3);
    chk(16'(status_word_q[SB_FAIL]), 16'h0000);
    @(posedge ref_clk) op_prot_hit <= 1'b1;
    @(posedge ref_clk) op_prot_hit <= 1'b0;
    cyc(3);
    chk(16'(status_word_q[SB_FAIL]), 16'h0001);
    $display("test flags done");
  endtask : t_flags
  task automatic t_hwp();
    wr(OP_WR_ST, 16'h0080, 8);
    idle();
    chk(16'(status_word_q[7:0]), 16'h0080);
    @(posedge ref_clk) wp_n <= 1'b0;
    wr(OP_WR_ST, 16'h0084, 8);
    cyc(2);
    chk(16'({busy_bit_q, status_word_q[7:2]}), 16'h0020);
    @(posedge ref_clk) wp_n <= 1'b1;
    $display("test protect done");
  endtask : t_hwp
  // Pin set to reset function: presets block locks and drops the volatile config bits
  task automatic t_pin();
    wr(OP_WR_CFG, 16'h0083, 8);
    idle();
    chk(16'(config_byte_q), 16'h0083);
    @(posedge ref_clk) mf_n <= 1'b0;
    cyc(6);
    chk(16'({hold_active_q, lock_preset_q}), 16'h0001);
    chk(16'(lock_preset_q), 16'h0001);
    chk(16'({dummy_dual_q, dummy_quad_q, dummy_dtr_q}), 16'h0468);
    @(posedge ref_clk) dtr_dummy <= 1'b1;
    cyc(3);
    chk(16'({learn_oe_q, learn_io_q}), 16'h0000);
    @(posedge ref_clk) {mf_n, dtr_dummy} <= 2'b10;
    cyc(4);
    chk(16'(lock_preset_q), 16'h0000);
    $display("test reset pin done");
  endtask : t_pin

  task automatic stop_test();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  initial begin
    rstn = 1'b0;
    {wp_n, mf_n, op_busy, op_done, op_ok, op_prot_hit, dtr_dummy} = 7'b1100000;
    dummy_idx = 3'h0;
    cyc(20);
    chk(16'(lock_preset_q), 16'h0001);
    @(posedge ref_clk) rstn <= 1'b1;
    cyc(4);
    t_reset();
    t_word();
    t_byte();
    t_cfg();
    t_vol();
    t_flags();
    t_hwp();
    t_pin();
    stop_test();
  end

  // Full run is about 34k cycles; over twice that means a hang
  initial begin
    repeat (90000) @(posedge ref_clk);
    err_count++;
    stop_test();
  end
endmodule : fsc_regs_tb_top
